// ### rtl/bfps_defs.vh
// Constants for the ballast fault protection sequencer
`ifndef BFPS_DEFS_VH
`define BFPS_DEFS_VH
// Clock rate in kHz
`define BFPS_CLK_KHZ        25000
// Qualification times in microseconds
`define BFPS_T_STARTTH_US   1
`define BFPS_T_UVLO_US      5
`define BFPS_T_FIL_US       100
`define BFPS_T_F620_US      620
`define BFPS_T_OPENLOOP_US  1
`define BFPS_T_OV_US        5
`define BFPS_T_PU_CHECK_US  10
`define BFPS_T_BUSUV_US     84
`define BFPS_T_BUSUV_DLY_US 120
// Long times in milliseconds
`define BFPS_T_SHUT_MS      625
`define BFPS_T_STARTUP_MS   80
`define BFPS_T_UV_WAIT_MS   100
`define BFPS_T_RESTART_MS   200
`define BFPS_T_EOL2_MS      2500
// Undervoltage restart limit
`define BFPS_UV_MAX_RESTART 7
// Cycle counts, least times rounded up
`define BFPS_US2CYC(t)      (((t) * `BFPS_CLK_KHZ + 999) / 1000)
`define BFPS_MS2CYC(t)      ((t) * `BFPS_CLK_KHZ)
// APB register byte addresses
`define BFPS_ADDR_CTRL      12'h000
`define BFPS_ADDR_STATUS    12'h004
`define BFPS_ADDR_IRQ_STAT  12'h008
`define BFPS_ADDR_IRQ_MASK  12'h00c
// Control register bit positions
`define BFPS_CTRL_RUN_REQ   0
`define BFPS_CTRL_CLR_LATCH 1
// Interrupt status bit positions
`define BFPS_IRQ_POWERDOWN  0
`define BFPS_IRQ_LATCHED    1
`define BFPS_IRQ_BOOST_OFF  2
`define BFPS_IRQ_BLOCKED    3
`define BFPS_IRQ_W          4
`endif

// ### rtl/bfps_sequencer.v
// Fault supervision and restart sequencer for a lamp ballast controller
`timescale 1ns/1ps
`include "bfps_defs.vh"

module bfps_sequencer #(
   parameter T_SHUT_CYC    = `BFPS_MS2CYC(`BFPS_T_SHUT_MS),     // Run open-loop / overvoltage time
   parameter T_STARTUP_CYC = `BFPS_MS2CYC(`BFPS_T_STARTUP_MS),  // Start-up target timeout
   parameter T_UVWAIT_CYC  = `BFPS_MS2CYC(`BFPS_T_UV_WAIT_MS),  // Undervoltage restart wait
   parameter T_RESTART_CYC = `BFPS_MS2CYC(`BFPS_T_RESTART_MS),  // Timed restart wait
   parameter T_EOL2_CYC    = `BFPS_MS2CYC(`BFPS_T_EOL2_MS),     // Rectify / idling time
   parameter T_START_CYC   = 32'd250000                         // Start-up phase length before run
) (
   // Clock, reset, enable
   input  wire        clk_i,
   input  wire        rstn_i,
   input  wire        ce_i,
   // Comparator flags
   input  wire        vcc_below_start_i,     // Supply below start threshold
   input  wire        vcc_uvlo_i,            // Supply below lockout threshold
   input  wire        vcc_hyst_cycle_i,      // Supply hysteresis cycle completed (pulse)
   input  wire        lvs_cur_low_i,         // lamp_voltage_sense current below threshold
   input  wire        fil_ls_low_th_i,       // Low-side filament above lower threshold
   input  wire        fil_ls_high_th_i,      // Low-side filament above upper threshold
   input  wire        bus_open_loop_i,       // Bus below open-loop level
   input  wire        bus_under_i,           // Bus below undervoltage level
   input  wire        bus_start_ok_i,        // Bus reached start-up target
   input  wire        bus_ov_high_i,         // Bus above upper overvoltage level
   input  wire        bus_ov_low_i,          // Bus above lower overvoltage level
   input  wire        end_of_life_peak_i,    // Lamp voltage peak beyond threshold
   input  wire        end_of_life_rectify_i, // Lamp voltage offset beyond threshold
   input  wire        cap_idle_i,            // Capacitive idling load
   input  wire        cap_overload_i,        // Below resonance with capacitive overload
   // APB slave
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [11:0] paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output reg         pready_o,
   output reg         pslverr_o,
   // Gate drive and status
   output reg         gate_en_o,             // Inverter gate drives enabled
   output reg         boost_en_o,            // Boost switch enabled
   output reg         skip_preheat_o,        // Restart without preheating
   output reg         irq_o                  // Level interrupt
);

   // One-hot states
   localparam [6:0] S_MONITOR = 7'h01;
   localparam [6:0] S_POWERUP = 7'h02;
   localparam [6:0] S_START   = 7'h04;
   localparam [6:0] S_RUN     = 7'h08;
   localparam [6:0] S_WAIT    = 7'h10;
   localparam [6:0] S_HOLD    = 7'h20;
   localparam [6:0] S_LATCHED = 7'h40;

   // Short qualification counts
   localparam [15:0] C_STARTTH = `BFPS_US2CYC(`BFPS_T_STARTTH_US);
   localparam [15:0] C_UVLO    = `BFPS_US2CYC(`BFPS_T_UVLO_US);
   localparam [15:0] C_FIL     = `BFPS_US2CYC(`BFPS_T_FIL_US);
   localparam [15:0] C_F620    = `BFPS_US2CYC(`BFPS_T_F620_US);
   localparam [15:0] C_OPENLP  = `BFPS_US2CYC(`BFPS_T_OPENLOOP_US);
   localparam [15:0] C_OV      = `BFPS_US2CYC(`BFPS_T_OV_US);
   localparam [15:0] C_PUCHK   = `BFPS_US2CYC(`BFPS_T_PU_CHECK_US);
   localparam [15:0] C_BUSUV   = `BFPS_US2CYC(`BFPS_T_BUSUV_US + `BFPS_T_BUSUV_DLY_US);

   // Qualifier indices
   localparam NQ = 14;
   localparam Q_STARTTH = 0, Q_UVLO = 1, Q_LVS = 2, Q_FILLO = 3, Q_FILHI = 4, Q_OPENLP = 5;
   localparam Q_SHUT = 6, Q_BUSUV = 7, Q_OVPU = 8, Q_OVBST = 9, Q_OVRUN = 10;
   localparam Q_EOL1 = 11, Q_EOL2 = 12, Q_CAP2 = 13;

   reg  [6:0]    state_reg;                  // Sequencer state
   reg  [31:0]   tmr_reg;                    // Phase timer
   reg  [6:0]    ret_reg;                    // Kind of wait (timed, open-loop bus, overvoltage bus)
   reg           fault_once_reg;             // One single-restart fault seen
   reg  [2:0]    uv_cnt_reg;                 // Undervoltage restarts used
   reg           boost_hold_ov_reg;          // Boost held off by overvoltage
   reg           run_req_reg;                // Software enable for power-up
   reg  [3:0]    irq_stat_reg;               // Sticky events
   reg  [3:0]    irq_mask_reg;               // Interrupt mask
   reg  [31:0]   qcnt_reg [0:NQ-1];          // Qualification timers
   wire [NQ-1:0] qflag;                      // Raw flag per qualifier
   wire [NQ-1:0] qen;                        // Mode enable per qualifier
   wire [NQ-1:0] qual;                       // Qualified condition
   wire [31:0]   qlim [0:NQ-1];              // Qualification length

   wire in_mon  = state_reg == S_MONITOR;
   wire in_pu   = state_reg == S_POWERUP;
   wire in_act  = (state_reg == S_START) | (state_reg == S_RUN);
   wire in_run  = state_reg == S_RUN;
   wire pu_chk  = in_pu & (tmr_reg >= {16'h0000, C_PUCHK});

   // Flag, mode enable and duration per qualifier
   assign qflag = {cap_overload_i, end_of_life_rectify_i | cap_idle_i, end_of_life_peak_i, bus_ov_high_i,
                   bus_ov_high_i, bus_ov_high_i, bus_under_i, bus_open_loop_i, bus_open_loop_i,
                   fil_ls_high_th_i, fil_ls_low_th_i, lvs_cur_low_i, vcc_uvlo_i, vcc_below_start_i};
   assign qen   = {in_run, in_run, in_run, in_run, in_act, pu_chk, in_run, in_run, in_act | pu_chk,
                   in_run, in_mon, in_mon, 1'b1, in_mon};
   assign qlim[Q_STARTTH] = {16'h0000, C_STARTTH};
   assign qlim[Q_UVLO]    = {16'h0000, C_UVLO};
   assign qlim[Q_LVS]     = {16'h0000, C_FIL};
   assign qlim[Q_FILLO]   = {16'h0000, C_FIL};
   assign qlim[Q_FILHI]   = {16'h0000, C_F620};
   assign qlim[Q_OPENLP]  = {16'h0000, C_OPENLP};
   assign qlim[Q_SHUT]    = T_SHUT_CYC;
   assign qlim[Q_BUSUV]   = {16'h0000, C_BUSUV};
   assign qlim[Q_OVPU]    = {16'h0000, C_OV};
   assign qlim[Q_OVBST]   = {16'h0000, C_OV};
   assign qlim[Q_OVRUN]   = T_SHUT_CYC;
   assign qlim[Q_EOL1]    = {16'h0000, C_F620};
   assign qlim[Q_EOL2]    = T_EOL2_CYC;
   assign qlim[Q_CAP2]    = {16'h0000, C_F620};

   // Continuous-duration qualifiers, cleared on any gap or disabled mode
   genvar gi;
   generate
      for (gi = 0; gi < NQ; gi = gi + 1) begin : g_qual
         always @(posedge clk_i) begin
            if (!rstn_i) begin
               qcnt_reg[gi] <= 32'h00000000;
            end else if (ce_i) begin
               if (qflag[gi] && qen[gi]) begin
                  if (qcnt_reg[gi] < qlim[gi])
                     qcnt_reg[gi] <= qcnt_reg[gi] + 32'h00000001;
               end else begin
                  qcnt_reg[gi] <= 32'h00000000;
               end
            end
         end
         assign qual[gi] = qflag[gi] & qen[gi] & (qcnt_reg[gi] >= qlim[gi]);
      end
   endgenerate

   // Fault groupings
   wire block_pu = qual[Q_STARTTH] | qual[Q_LVS] | qual[Q_FILLO];
   wire f_fault  = qual[Q_FILHI] | qual[Q_EOL1] | qual[Q_EOL2] | qual[Q_CAP2];
   wire pu_hold  = qual[Q_OPENLP] | qual[Q_OVPU];

   // APB access strobes
   wire apb_acc = psel_i & penable_i & pready_o;
   wire apb_wr  = apb_acc & pwrite_i;
   wire wr_ctrl = apb_wr & (paddr_i == `BFPS_ADDR_CTRL);
   wire clr_latch = wr_ctrl & pwdata_i[`BFPS_CTRL_CLR_LATCH];

   // Event pulses
   reg  [3:0] ev;
   reg  [6:0] state_next;
   reg  [6:0] ret_next;
   reg  [31:0] tmr_next;
   reg        fault_once_next;
   reg  [2:0] uv_cnt_next;
   reg        skip_next;

   // Sequencer next-state logic
   always @* begin
      state_next      = state_reg;
      ret_next        = ret_reg;
      tmr_next        = tmr_reg + 32'h00000001;
      fault_once_next = fault_once_reg;
      uv_cnt_next     = uv_cnt_reg;
      skip_next       = skip_preheat_o;
      ev              = 4'h0;
      if (qual[Q_UVLO]) begin
         // Lockout overrides every mode
         state_next      = S_MONITOR;
         fault_once_next = 1'b0;
         uv_cnt_next     = 3'h0;
         skip_next       = 1'b0;
         tmr_next        = 32'h00000000;
         ev[`BFPS_IRQ_POWERDOWN] = ~in_mon;
      end else begin
         case (state_reg)
            S_MONITOR: begin
               // Wait for clear checks and software enable
               if (block_pu) begin
                  ev[`BFPS_IRQ_BLOCKED] = 1'b1;
               end else if (run_req_reg) begin
                  state_next = S_POWERUP;
                  tmr_next   = 32'h00000000;
               end
            end
            S_POWERUP: begin
               // Bus check at power-up, gates held off on failure
               if (pu_hold) begin
                  state_next = S_HOLD;
                  ev[`BFPS_IRQ_POWERDOWN] = 1'b1;
               end else if (tmr_reg >= {16'h0000, C_PUCHK} + {16'h0000, C_OV}) begin
                  state_next = S_START;
                  tmr_next   = 32'h00000000;
               end
            end
            S_START: begin
               // Bus must reach start-up target in time
               if (!bus_start_ok_i && tmr_reg >= T_STARTUP_CYC) begin
                  state_next = S_WAIT;
                  ret_next   = S_MONITOR;
                  tmr_next   = T_RESTART_CYC;
                  ev[`BFPS_IRQ_POWERDOWN] = 1'b1;
               end else if (bus_start_ok_i && tmr_reg >= T_START_CYC) begin
                  state_next = S_RUN;
                  tmr_next   = 32'h00000000;
               end
            end
            S_RUN: begin
               // Run-mode faults by priority
               if (f_fault) begin
                  ev[`BFPS_IRQ_POWERDOWN] = 1'b1;
                  if (fault_once_reg) begin
                     state_next = S_LATCHED;
                     ev[`BFPS_IRQ_LATCHED] = 1'b1;
                  end else begin
                     fault_once_next = 1'b1;
                     state_next = S_WAIT;
                     ret_next   = S_MONITOR;
                     tmr_next   = T_RESTART_CYC;
                  end
               end else if (qual[Q_BUSUV]) begin
                  ev[`BFPS_IRQ_POWERDOWN] = 1'b1;
                  if (uv_cnt_reg == 3'd`BFPS_UV_MAX_RESTART) begin
                     state_next = S_LATCHED;
                     ev[`BFPS_IRQ_LATCHED] = 1'b1;
                  end else begin
                     uv_cnt_next = uv_cnt_reg + 3'h1;
                     skip_next   = 1'b1;
                     state_next  = S_WAIT;
                     ret_next    = S_MONITOR;
                     tmr_next    = T_UVWAIT_CYC;
                  end
               end else if (qual[Q_SHUT]) begin
                  state_next = S_WAIT;
                  ret_next   = S_WAIT;
                  tmr_next   = 32'h00000000;
                  ev[`BFPS_IRQ_POWERDOWN] = 1'b1;
               end else if (qual[Q_OVRUN]) begin
                  state_next = S_WAIT;
                  ret_next   = S_RUN;
                  tmr_next   = 32'h00000000;
                  ev[`BFPS_IRQ_POWERDOWN] = 1'b1;
               end
            end
            S_WAIT: begin
               // Timed wait, or wait on bus level (ret marks the kind)
               if (ret_reg == S_WAIT) begin
                  tmr_next = tmr_reg;
                  if (!bus_open_loop_i)
                     state_next = S_MONITOR;
               end else if (ret_reg == S_RUN) begin
                  tmr_next = tmr_reg;
                  if (!bus_ov_low_i)
                     state_next = S_MONITOR;
               end else begin
                  tmr_next = tmr_reg - 32'h00000001;
                  if (tmr_reg == 32'h00000000) begin
                     tmr_next   = 32'h00000000;
                     state_next = S_MONITOR;
                  end
               end
            end
            S_HOLD: begin
               // A supply hysteresis cycle or lockout releases
               if (vcc_hyst_cycle_i)
                  state_next = S_MONITOR;
            end
            S_LATCHED: begin
               // Stays off until lockout or software clear
               if (clr_latch) begin
                  state_next      = S_MONITOR;
                  fault_once_next = 1'b0;
                  uv_cnt_next     = 3'h0;
               end
            end
            default: begin
               state_next = S_MONITOR;
            end
         endcase
      end
   end

   // Sequencer registers and gate outputs
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         state_reg         <= S_MONITOR;
         ret_reg           <= S_MONITOR;
         tmr_reg           <= 32'h00000000;
         fault_once_reg    <= 1'b0;
         uv_cnt_reg        <= 3'h0;
         skip_preheat_o    <= 1'b0;
         gate_en_o         <= 1'b0;
         boost_en_o        <= 1'b0;
         boost_hold_ov_reg <= 1'b0;
      end else if (ce_i) begin
         state_reg      <= state_next;
         ret_reg        <= ret_next;
         tmr_reg        <= tmr_next;
         fault_once_reg <= fault_once_next;
         uv_cnt_reg     <= uv_cnt_next;
         skip_preheat_o <= skip_next;
         // Gates only in active modes
         gate_en_o      <= (state_next == S_START) | (state_next == S_RUN);
         // Overvoltage hold until bus below lower level
         if (qual[Q_OVBST])
            boost_hold_ov_reg <= 1'b1;
         else if (!bus_ov_low_i)
            boost_hold_ov_reg <= 1'b0;
         // Boost off while open-loop or overvoltage hold
         boost_en_o <= ((state_next == S_START) | (state_next == S_RUN)) & ~qual[Q_OPENLP]
                       & ~(qual[Q_OVBST] | (boost_hold_ov_reg & bus_ov_low_i));
      end
   end

   // APB slave, events, interrupt
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         prdata_o     <= 32'h00000000;
         pready_o     <= 1'b0;
         pslverr_o    <= 1'b0;
         run_req_reg  <= 1'b0;
         irq_stat_reg <= 4'h0;
         irq_mask_reg <= 4'h0;
         irq_o        <= 1'b0;
      end else if (ce_i) begin
         pready_o  <= psel_i & penable_i & ~pready_o;
         pslverr_o <= psel_i & penable_i & ~pready_o & (paddr_i > `BFPS_ADDR_IRQ_MASK);
         if (wr_ctrl)
            run_req_reg <= pwdata_i[`BFPS_CTRL_RUN_REQ];
         if (apb_wr && paddr_i == `BFPS_ADDR_IRQ_MASK)
            irq_mask_reg <= pwdata_i[3:0];
         // Set wins over write-one clear
         if (apb_wr && paddr_i == `BFPS_ADDR_IRQ_STAT)
            irq_stat_reg <= (irq_stat_reg & ~pwdata_i[3:0]) | ev;
         else
            irq_stat_reg <= irq_stat_reg | ev;
         irq_o <= |(irq_stat_reg & irq_mask_reg);
         // Read data during access phase
         if (psel_i && !pwrite_i && !pready_o) begin
            case (paddr_i)
               `BFPS_ADDR_CTRL:     prdata_o <= {31'h0, run_req_reg};
               `BFPS_ADDR_STATUS:   prdata_o <= {19'h0, uv_cnt_reg, fault_once_reg, boost_en_o, gate_en_o,
                                                 state_reg};
               `BFPS_ADDR_IRQ_STAT: prdata_o <= {28'h0, irq_stat_reg};
               `BFPS_ADDR_IRQ_MASK: prdata_o <= {28'h0, irq_mask_reg};
               default:             prdata_o <= 32'h00000000;
            endcase
         end
      end
   end

endmodule // bfps_sequencer

// ### testbench/bfps_sense_model.sv
// Sense comparator and bus charging model facing the sequencer
`timescale 1ns/1ps
module bfps_sense_model (
   // Clock and commands
   input  wire         clk_i,
   input  wire  [14:0] cmd_i,      // Forced comparator conditions
   input  wire  [7:0]  chg_dly_i,  // Bus charge time in cycles, small is prompt
   // Gate drive feedback
   input  wire         gate_en_i,
   input  wire         boost_en_i,
   // Comparator flags, bit 8 is start target reached
   output logic [14:0] flag_o
);
   logic [7:0] chg;  // Cycles of boost activity since the inverter went live
   // Bus only charges while the inverter is live and the boost switch runs
   always @(posedge clk_i) begin
      if (!gate_en_i) begin
         chg <= 8'h00;
      end else if (boost_en_i && chg != 8'hff) begin
         chg <= chg + 8'h01;
      end
   end
   // Start target follows the charge unless a stall is commanded
   always_comb begin
      flag_o    = cmd_i;
      flag_o[8] = (chg >= chg_dly_i) && !cmd_i[8];
   end
endmodule // bfps_sense_model

// ### testbench/bfps_sequencer_monitor.sv
// Port-level assertions for the fault protection sequencer
`timescale 1ns/1ps
module bfps_sequencer_monitor (
   // Clock and control
   input wire clk_i,
   input wire rstn_i,
   input wire ce_i,
   // Watched flags
   input wire vcc_uvlo_i,
   input wire fil_ls_high_th_i,
   input wire bus_open_loop_i,
   input wire bus_under_i,
   input wire bus_ov_high_i,
   input wire end_of_life_peak_i,
   input wire cap_overload_i,
   // Watched outputs
   input wire pready_o,
   input wire pslverr_o,
   input wire gate_en_o,
   input wire boost_en_o
);
   logic [15:0] uv_c, ol_c, ov_c, fh_c, pk_c, co_c, un_c;  // Consecutive high counts
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // Saturating increment while the flag holds, else clear
   function automatic logic [15:0] nx(input logic f, input logic [15:0] c);
      return f ? ((c == 16'hffff) ? c : c + 16'h0001) : 16'h0000;
   endfunction
   // Run-mode counts restart whenever the gates are off
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         {uv_c, ol_c, ov_c, fh_c, pk_c, co_c, un_c} <= '0;
      end else if (ce_i) begin
         uv_c <= nx(vcc_uvlo_i, uv_c);
         ol_c <= nx(bus_open_loop_i, ol_c);
         ov_c <= nx(bus_ov_high_i, ov_c);
         fh_c <= nx(fil_ls_high_th_i & gate_en_o, fh_c);
         pk_c <= nx(end_of_life_peak_i & gate_en_o, pk_c);
         co_c <= nx(cap_overload_i & gate_en_o, co_c);
         un_c <= nx(bus_under_i & gate_en_o, un_c);
      end
   end
   property p_uvlo; uv_c == 16'd127 |-> !gate_en_o && !boost_en_o; endproperty
   a_uvlo: assert property (p_uvlo) else $error("gates still on after lockout");
   property p_ol; ol_c == 16'd27 |-> !boost_en_o; endproperty
   a_ol: assert property (p_ol) else $error("boost on with low bus");
   property p_ov; ov_c == 16'd127 |-> !boost_en_o; endproperty
   a_ov: assert property (p_ov) else $error("boost on with high bus");
   property p_fil; fh_c == 16'd15502 |-> !gate_en_o; endproperty
   a_fil: assert property (p_fil) else $error("filament fault ignored");
   property p_peak; pk_c == 16'd15502 |-> !gate_en_o; endproperty
   a_peak: assert property (p_peak) else $error("peak fault ignored");
   property p_cap; co_c == 16'd15502 |-> !gate_en_o; endproperty
   a_cap: assert property (p_cap) else $error("overload fault ignored");
   property p_under; un_c == 16'd5102 |-> !gate_en_o; endproperty
   a_under: assert property (p_under) else $error("bus undervoltage ignored");
   property p_short; ov_c >= 16'd127 |-> !boost_en_o; endproperty
   a_short: assert property (p_short) else $error("boost on during lasting overvoltage");
   property p_rdy; pready_o |=> !pready_o; endproperty
   a_rdy: assert property (p_rdy) else $error("ready longer than one cycle");
   property p_err; pslverr_o |-> pready_o; endproperty
   a_err: assert property (p_err) else $error("error without ready");
endmodule // bfps_sequencer_monitor
bind bfps_sequencer bfps_sequencer_monitor u_mon (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
   .vcc_uvlo_i(vcc_uvlo_i), .fil_ls_high_th_i(fil_ls_high_th_i), .bus_open_loop_i(bus_open_loop_i),
   .bus_under_i(bus_under_i), .bus_ov_high_i(bus_ov_high_i), .end_of_life_peak_i(end_of_life_peak_i),
   .cap_overload_i(cap_overload_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .gate_en_o(gate_en_o),
   .boost_en_o(boost_en_o));

// ### testbench/tb_top.sv
// Self-checking bench for the fault protection sequencer
`timescale 1ns/1ps
`include "bfps_defs.vh"
module tb_top;
   logic        clk_i = 1'b0, rstn_i = 1'b0, ce_i = 1'b1;  // Clock, reset, enable
   logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;  // APB request
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
   logic        pready_o, pslverr_o, gate_en_o, boost_en_o, skip_preheat_o, irq_o, err;
   logic [14:0] cmd = 15'h0, flag;  // Forced conditions and resulting flags
   logic [7:0]  chg_dly = 8'd20;
   int          error_cnt = 0, n_compared = 0, cyc = 0, k;
   int          fb[4] = '{5, 11, 14, 12};  // Single-restart fault flags
   localparam int TIMEOUT = 95000;
   // Free-running clock
   initial forever #20 clk_i = ~clk_i;
   bfps_sense_model u_sense (.clk_i(clk_i), .cmd_i(cmd), .chg_dly_i(chg_dly), .gate_en_i(gate_en_o),
      .boost_en_i(boost_en_o), .flag_o(flag));
   bfps_sequencer #(.T_SHUT_CYC(200), .T_STARTUP_CYC(300), .T_UVWAIT_CYC(200), .T_RESTART_CYC(200),
      .T_EOL2_CYC(200), .T_START_CYC(200)) DUT (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
      .vcc_below_start_i(flag[0]), .vcc_uvlo_i(flag[1]), .vcc_hyst_cycle_i(flag[2]), .lvs_cur_low_i(flag[3]),
      .fil_ls_low_th_i(flag[4]), .fil_ls_high_th_i(flag[5]), .bus_open_loop_i(flag[6]), .bus_under_i(flag[7]),
      .bus_start_ok_i(flag[8]), .bus_ov_high_i(flag[9]), .bus_ov_low_i(flag[10]), .end_of_life_peak_i(flag[11]),
      .end_of_life_rectify_i(flag[12]), .cap_idle_i(flag[13]), .cap_overload_i(flag[14]), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .gate_en_o(gate_en_o), .boost_en_o(boost_en_o),
      .skip_preheat_o(skip_preheat_o), .irq_o(irq_o));
   // Verdict and end of run
   task automatic test_done;
      if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer, waiting for ready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do @(posedge clk_i); while (pready_o !== 1'b1 && ++n < 50);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   // Poll the state field until it matches
   task automatic wait_st(input logic [6:0] s);
      int n;
      n = 0;
      rd = 32'h0;
      while (rd[6:0] !== s && n < 4000) begin
         apb(1'b0, `BFPS_ADDR_STATUS, 32'h0);
         n++;
      end
   endtask
   // Hold one flag for a number of samples
   task automatic hold(input int b, input int n);
      cmd[b] <= 1'b1;
      repeat (n) @(posedge clk_i);
      cmd[b] <= 1'b0;
   endtask
   // Expected status word
   function automatic logic [31:0] stx(input logic [6:0] s, input logic g, b, u, input logic [2:0] n);
      return {19'h0, n, u, b, g, s};
   endfunction
   // Hang guard
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == TIMEOUT) begin
         error_cnt++;
         test_done();
      end
   end
   // Main sequence
   initial begin
      k = $urandom(32'hfebd6ba3);
      chg_dly = 8'($urandom_range(4, 200));
      repeat (20) @(posedge clk_i);
      rstn_i <= 1'b1;
      apb(1'b0, `BFPS_ADDR_STATUS, 32'h0);
      chk(rd, stx(7'h01, 0, 0, 0, 0));
      apb(1'b0, 12'h010, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      foreach (fb[i]) if (i < 3) begin
         k = (i == 0) ? 0 : i + 2;
         cmd[k] <= 1'b1;
         repeat (2600) @(posedge clk_i);
         apb(1'b1, `BFPS_ADDR_CTRL, 32'h1);
         repeat (50) @(posedge clk_i);
         apb(1'b0, `BFPS_ADDR_STATUS, 32'h0);
         chk(rd, stx(7'h01, 0, 0, 0, 0));
         apb(1'b1, `BFPS_ADDR_CTRL, 32'h0);
         cmd[k] <= 1'b0;
      end
      apb(1'b1, `BFPS_ADDR_IRQ_MASK, 32'h8);
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1'b1);
      apb(1'b1, `BFPS_ADDR_IRQ_STAT, 32'h8);
      apb(1'b0, `BFPS_ADDR_IRQ_STAT, 32'h0);
      chk(rd | irq_o, 32'h0);
      apb(1'b1, `BFPS_ADDR_IRQ_MASK, 32'h3);
      apb(1'b1, `BFPS_ADDR_CTRL, 32'h1);
      wait_st(7'h08);
      chk(rd, stx(7'h08, 1, 1, 0, 0));
      hold(6, $urandom_range(1, 20));
      chk(boost_en_o, 1'b1);
      ce_i <= 1'b0;
      cmd[6] <= 1'b1;
      repeat (40) @(posedge clk_i);
      chk(boost_en_o, 1'b1);
      ce_i <= 1'b1;
      repeat (30) @(posedge clk_i);
      chk({gate_en_o, boost_en_o}, 2'b10);
      cmd[6] <= 1'b0;
      cmd[10:9] <= 2'b11;
      repeat (5) @(posedge clk_i);
      chk(boost_en_o, 1'b1);
      repeat (125) @(posedge clk_i);
      cmd[9] <= 1'b0;
      repeat (20) @(posedge clk_i);
      chk({gate_en_o, boost_en_o}, 2'b10);
      cmd[10] <= 1'b0;
      repeat (5) @(posedge clk_i);
      chk(boost_en_o, 1'b1);
      foreach (fb[i]) begin
         k = (fb[i] == 12) ? 200 : 15500;
         hold(fb[i], k + $urandom_range(2, 40));
         wait_st(i[0] ? 7'h40 : 7'h10);
         chk(rd, stx(i[0] ? 7'h40 : 7'h10, 0, 0, 1, 0));
         chk(irq_o, 1'b1);
         apb(1'b1, `BFPS_ADDR_IRQ_STAT, 32'h3);
         if (i[0]) begin
            apb(1'b1, `BFPS_ADDR_CTRL, 32'h0);
            hold(1, 130);
            wait_st(7'h01);
            chk(rd, stx(7'h01, 0, 0, 0, 0));
            apb(1'b1, `BFPS_ADDR_CTRL, 32'h1);
         end
         wait_st(7'h08);
         chk(rd, stx(7'h08, 1, 1, !i[0], 0));
      end
      for (int b = 6; b <= 9; b += 3) begin
         cmd[b] <= 1'b1;
         repeat (215) @(posedge clk_i);
         chk(gate_en_o, 1'b0);
         cmd[b] <= 1'b0;
         wait_st(7'h08);
      end
      hold(7, 5100 + $urandom_range(2, 40));
      chk(gate_en_o, 1'b0);
      wait_st(7'h08);
      chk({skip_preheat_o, rd}, {1'b1, stx(7'h08, 1, 1, 0, 1)});
      test_done();
   end
endmodule // tb_top
